// ==== hdl/cbf_pkg.sv ====
// Shared constants, state types and the checksum step of the block framer
package cbf_pkg;

  // Block size limits, counted in bytes including count and checksum
  localparam logic [7:0] CBF_CNT_MIN = 8'h04;
  localparam logic [7:0] CBF_CNT_MAX = 8'h54;
  // Count byte plus the two checksum bytes
  localparam logic [7:0] CBF_OVERHEAD = 8'h03;
  // Distance from the index held after the last packet byte to the count value
  localparam logic [7:0] CBF_IDX_END = 8'h02;
  // Index of the first packet byte
  localparam logic [7:0] CBF_IDX_FIRST = 8'h01;

  // Checksum generator and start value
  localparam logic [15:0] CBF_CRC_POLY = 16'h8005;
  localparam logic [15:0] CBF_CRC_INIT = 16'h0000;

  // Status byte and size of the four-byte status block
  localparam logic [7:0] CBF_ST_COMM_ERR = 8'hFF;
  localparam logic [7:0] CBF_ERR_BLK = 8'h04;
  localparam logic [7:0] CBF_ERR_PKT = 8'h01;

  // Reset values
  localparam logic [7:0] CBF_BYTE_RST = 8'h00;
  localparam logic [15:0] CBF_CRC_RST = 16'h0000;

  // Default buffer shape
  localparam int CBF_FIFO_W = 8;
  localparam int CBF_FIFO_D = 8;

  typedef enum logic [1:0] {
    R_CNT,
    R_PKT,
    R_CLO,
    R_CHI
  } cbf_rx_e;

  typedef enum logic [1:0] {
    T_IDLE,
    T_PKT,
    T_CHI,
    T_END
  } cbf_tx_e;

  // One byte into the checksum, bit 0 first as it travels on the link
  function automatic logic [15:0] cbf_crc_byte(input logic [15:0] crc,
                                               input logic [7:0] data);
    logic [15:0] c;
    c = crc;
    for (int i = 0; i < 8; i++) begin
      if (data[i] != c[15]) begin
        c = {c[14:0], 1'b0} ^ CBF_CRC_POLY;
      end else begin
        c = {c[14:0], 1'b0};
      end
    end
    return c;
  endfunction : cbf_crc_byte

endpackage : cbf_pkg

// ==== hdl/cbf_fifo.sv ====
// Packet byte buffer with registered read stage
`timescale 1ns/1ps
`default_nettype none
module cbf_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  output logic in_room2,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  import cbf_pkg::*;

  localparam int AW = (D > 1) ? $clog2(D) : 1;
  // Full depth needs one bit more than the pointers, or eight folds to zero
  localparam logic [AW:0] DEPTH = (AW + 1)'(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic ov;
    logic [W-1:0] od;
    logic rdy;
    logic room2;
  } cbf_fifo_s;

  cbf_fifo_s st_ff;
  cbf_fifo_s nxt_st;

  logic push;
  logic pop;

  ////////////////////////////////////////////////////////////////////////////
  // Next state: store on push, refill the output stage when it empties
  always_comb begin
    nxt_st = st_ff;
    push = in_valid && st_ff.rdy;
    pop = (!st_ff.ov || out_ready) && (st_ff.cnt != '0);
    if (st_ff.ov && out_ready) begin
      nxt_st.ov = 1'b0;
    end
    if (push) begin
      nxt_st.mem[st_ff.wp] = in_data;
      nxt_st.wp = (st_ff.wp == AW'(D - 1)) ? '0 : st_ff.wp + 1'b1;
    end
    if (pop) begin
      nxt_st.od = st_ff.mem[st_ff.rp];
      nxt_st.ov = 1'b1;
      nxt_st.rp = (st_ff.rp == AW'(D - 1)) ? '0 : st_ff.rp + 1'b1;
    end
    nxt_st.cnt = st_ff.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
    // Ready is registered, so it looks at the next fill level
    nxt_st.rdy = nxt_st.cnt < DEPTH;
    nxt_st.room2 = nxt_st.cnt < (DEPTH - (AW + 1)'(1));
  end

  // State register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign in_ready = st_ff.rdy;
  assign in_room2 = st_ff.room2;
  assign out_valid = st_ff.ov;
  assign out_data = st_ff.od;

endmodule : cbf_fifo
`default_nettype wire

// ==== hdl/cbf_framer.sv ====
// Block framer: count byte, packet, checksum on receive and transmit
`timescale 1ns/1ps
`default_nettype none
module cbf_framer #(
  parameter int FIFO_W = cbf_pkg::CBF_FIFO_W,
  parameter int FIFO_D = cbf_pkg::CBF_FIFO_D
) (
  input wire logic mclk,
  input wire logic sys_rst,
  // Received bytes from the link layer
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic [7:0] rx_data,
  // Packet bytes towards the command executor
  output logic pkt_valid,
  input wire logic pkt_ready,
  output logic [FIFO_W-1:0] pkt_data,
  output logic frame_ok,
  output logic frame_err,
  output logic [7:0] frame_count,
  // Response packet from the command executor
  input wire logic rsp_start,
  input wire logic [7:0] rsp_len,
  input wire logic rsp_valid,
  output logic rsp_ready,
  input wire logic [7:0] rsp_data,
  // Four-byte status request from the executor
  input wire logic err_req,
  input wire logic [7:0] err_code,
  // Transmitted bytes to the link layer
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_data,
  output logic tx_busy
);
  import cbf_pkg::*;

  typedef struct packed {
    cbf_rx_e rst;
    logic [7:0] cnt;
    logic [7:0] idx;
    logic [15:0] rcrc;
    logic [7:0] clo;
    logic rx_ready;
    logic frame_ok;
    logic frame_err;
    logic err_pend;
    cbf_tx_e tst;
    logic [7:0] tcnt;
    logic [15:0] tcrc;
    logic tx_valid;
    logic [7:0] tx_data;
    logic rsp_ready;
    logic err_mode;
    logic [7:0] err_code;
    logic tx_busy;
  } cbf_state_s;

  cbf_state_s st_ff;
  cbf_state_s nxt_st;
  logic take;
  logic push;
  logic sent;
  logic free;
  logic fifo_room2;
  logic [7:0] blk_len;

  ////////////////////////////////////////////////////////////////////////////
  // Packet buffer; the executor can stall it and so stall the link
  cbf_fifo #(
    .W(FIFO_W),
    .D(FIFO_D)
  ) u_fifo (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .in_valid(push),
    .in_ready(),
    .in_room2(fifo_room2),
    .in_data(FIFO_W'(rx_data)),
    .out_valid(pkt_valid),
    .out_ready(pkt_ready),
    .out_data(pkt_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Receive and transmit sequencing in one next-state block
  always_comb begin
    nxt_st = st_ff;
    take = rx_valid && st_ff.rx_ready;
    push = 1'b0;
    sent = st_ff.tx_valid && tx_ready;
    blk_len = CBF_BYTE_RST;
    nxt_st.frame_ok = 1'b0;
    nxt_st.frame_err = 1'b0;

    // Receive side; the count byte decides where the block ends
    case (st_ff.rst)
      R_CNT: begin
        if (take) begin
          if (rx_data < CBF_CNT_MIN || rx_data > CBF_CNT_MAX) begin
            nxt_st.frame_err = 1'b1;
          end else begin
            nxt_st.cnt = rx_data;
            nxt_st.idx = CBF_IDX_FIRST;
            nxt_st.rcrc = cbf_crc_byte(CBF_CRC_INIT, rx_data);
            nxt_st.rst = R_PKT;
          end
        end
      end
      R_PKT: begin
        if (take) begin
          push = 1'b1;
          nxt_st.rcrc = cbf_crc_byte(st_ff.rcrc, rx_data);
          nxt_st.idx = st_ff.idx + 8'h01;
          if (st_ff.idx == st_ff.cnt - CBF_OVERHEAD) begin
            nxt_st.rst = R_CLO;
          end
        end
      end
      R_CLO: begin
        if (take) begin
          nxt_st.clo = rx_data;
          nxt_st.rst = R_CHI;
        end
      end
      R_CHI: begin
        if (take) begin
          // Compared only after exactly count bytes
          if ({rx_data, st_ff.clo} == st_ff.rcrc) begin
            nxt_st.frame_ok = 1'b1;
          end else begin
            nxt_st.frame_err = 1'b1;
          end
          nxt_st.rst = R_CNT;
        end
      end
      default: nxt_st.rst = R_CNT;
    endcase

    // Transmit side; the held byte slot is free once it has been taken
    free = !st_ff.tx_valid || sent;
    if (sent) begin
      nxt_st.tx_valid = 1'b0;
    end
    case (st_ff.tst)
      T_IDLE: begin
        if (st_ff.err_pend || err_req || rsp_start) begin
          if (st_ff.err_pend) begin
            nxt_st.err_pend = 1'b0;
            nxt_st.err_mode = 1'b1;
            nxt_st.err_code = CBF_ST_COMM_ERR;
            nxt_st.tcnt = CBF_ERR_PKT;
          end else if (err_req) begin
            nxt_st.err_mode = 1'b1;
            nxt_st.err_code = err_code;
            nxt_st.tcnt = CBF_ERR_PKT;
          end else begin
            nxt_st.err_mode = 1'b0;
            nxt_st.tcnt = rsp_len;
          end
          blk_len = nxt_st.tcnt + CBF_OVERHEAD;
          nxt_st.tx_data = blk_len;
          nxt_st.tx_valid = 1'b1;
          nxt_st.tcrc = cbf_crc_byte(CBF_CRC_INIT, blk_len);
          nxt_st.tst = T_PKT;
        end
      end
      T_PKT: begin
        if (free) begin
          if (st_ff.tcnt == CBF_BYTE_RST) begin
            nxt_st.tx_data = st_ff.tcrc[7:0];
            nxt_st.tx_valid = 1'b1;
            nxt_st.tst = T_CHI;
          end else if (st_ff.err_mode) begin
            nxt_st.tx_data = st_ff.err_code;
            nxt_st.tx_valid = 1'b1;
            nxt_st.tcrc = cbf_crc_byte(st_ff.tcrc, st_ff.err_code);
            nxt_st.tcnt = st_ff.tcnt - 8'h01;
          end else if (st_ff.rsp_ready && rsp_valid) begin
            nxt_st.tx_data = rsp_data;
            nxt_st.tx_valid = 1'b1;
            nxt_st.tcrc = cbf_crc_byte(st_ff.tcrc, rsp_data);
            nxt_st.tcnt = st_ff.tcnt - 8'h01;
          end
        end
      end
      T_CHI: begin
        if (sent) begin
          nxt_st.tx_data = st_ff.tcrc[15:8];
          nxt_st.tx_valid = 1'b1;
          nxt_st.tst = T_END;
        end
      end
      T_END: begin
        if (sent) begin
          nxt_st.tst = T_IDLE;
        end
      end
      default: nxt_st.tst = T_IDLE;
    endcase

    // A failure raised while the old one is taken still survives
    if (nxt_st.frame_err) begin
      nxt_st.err_pend = 1'b1;
    end

    // Ready flags are registered; two free slots cover the one-cycle lag.
    // Input is held off while any answer is pending or going out.
    nxt_st.rx_ready = fifo_room2 && !nxt_st.err_pend &&
                      (nxt_st.tst == T_IDLE) && !err_req && !rsp_start;
    nxt_st.rsp_ready = (nxt_st.tst == T_PKT) && !nxt_st.tx_valid &&
                       (nxt_st.tcnt != CBF_BYTE_RST) && !nxt_st.err_mode;
    nxt_st.tx_busy = nxt_st.tst != T_IDLE;
  end

  // State register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register
  assign rx_ready = st_ff.rx_ready;
  assign frame_ok = st_ff.frame_ok;
  assign frame_err = st_ff.frame_err;
  assign frame_count = st_ff.cnt;
  assign rsp_ready = st_ff.rsp_ready;
  assign tx_valid = st_ff.tx_valid;
  assign tx_data = st_ff.tx_data;
  assign tx_busy = st_ff.tx_busy;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence s_tx_open;
    st_ff.tst == T_IDLE ##1 st_ff.tst == T_PKT;
  endsequence

  sequence s_last_in;
    take && st_ff.rst == R_CHI;
  endsequence

  property p_count_first;
    s_tx_open |-> tx_data == st_ff.tcnt + CBF_OVERHEAD;
  endproperty
  a_count_first: assert property (p_count_first)
    else $error("count byte does not match block length");

  property p_crc_zero;
    s_tx_open |-> st_ff.tcrc == cbf_crc_byte(CBF_CRC_INIT, tx_data);
  endproperty
  a_crc_zero: assert property (p_crc_zero)
    else $error("checksum did not start from zero");

  property p_low_first;
    st_ff.tst == T_PKT ##1 st_ff.tst == T_CHI
      |-> tx_valid && tx_data == st_ff.tcrc[7:0];
  endproperty
  a_low_first: assert property (p_low_first)
    else $error("checksum low byte not sent first");

  property p_high_last;
    st_ff.tst == T_CHI && sent
      |=> st_ff.tst == T_END && tx_data == $past(st_ff.tcrc[15:8]);
  endproperty
  a_high_last: assert property (p_high_last)
    else $error("checksum high byte not last");

  property p_accept_match;
    s_last_in |=> frame_ok == ($past(st_ff.rcrc) ==
                               {$past(rx_data), $past(st_ff.clo)});
  endproperty
  a_accept_match: assert property (p_accept_match)
    else $error("block accepted or refused against checksum");

  property p_end_at_count;
    s_last_in |-> st_ff.idx == st_ff.cnt - CBF_IDX_END;
  endproperty
  a_end_at_count: assert property (p_end_at_count)
    else $error("block ended before count bytes");

  property p_range;
    take && st_ff.rst == R_CNT &&
      (rx_data < CBF_CNT_MIN || rx_data > CBF_CNT_MAX)
      |=> frame_err && st_ff.rst == R_CNT && st_ff.err_pend;
  endproperty
  a_range: assert property (p_range)
    else $error("bad count not refused");

  property p_comm_err_blk;
    st_ff.tst == T_IDLE && st_ff.err_pend
      |=> tx_valid && tx_data == CBF_ERR_BLK &&
          st_ff.err_code == CBF_ST_COMM_ERR && st_ff.err_mode;
  endproperty
  a_comm_err_blk: assert property (p_comm_err_blk)
    else $error("communications error block not started");

  property p_size_err;
    st_ff.tst == T_IDLE && !st_ff.err_pend && err_req
      |=> tx_data == CBF_ERR_BLK && st_ff.err_code == $past(err_code);
  endproperty
  a_size_err: assert property (p_size_err)
    else $error("size error block not started");

  property p_half_duplex;
    st_ff.tst != T_IDLE |-> !rx_ready;
  endproperty
  a_half_duplex: assert property (p_half_duplex)
    else $error("input taken while a block goes out");

  property p_crc_step;
    take && st_ff.rst == R_PKT
      |=> st_ff.rcrc == cbf_crc_byte($past(st_ff.rcrc), $past(rx_data));
  endproperty
  a_crc_step: assert property (p_crc_step)
    else $error("receive checksum step wrong");

endmodule : cbf_framer
`default_nettype wire

// ==== bench/cbf_host_model.sv ====
// Host side model: takes outgoing block bytes, with optional stalls
`timescale 1ns/1ps
`default_nettype none
module cbf_host_model (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic slow,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  output logic got,
  output logic [7:0] got_data,
  output logic got_last
);
  logic [7:0] left = 8'h00;
  logic [1:0] ph = 2'h0;

  // Quiet outputs until the first edge
  initial begin
    tx_ready = 1'b0;
    got = 1'b0;
    got_data = 8'h00;
    got_last = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////
  // Ready one cycle in three when slow, so the sender must hold its byte
  always @(posedge mclk) begin
    #1;
    ph = (ph == 2'h2) ? 2'h0 : ph + 2'h1;
    tx_ready = !sys_rst && (!slow || ph == 2'h0);
  end

  //////////////////////////////////////////////////////////////////////////
  // Count byte tells how many bytes follow; sampled mid-cycle when settled
  always @(negedge mclk) begin
    got = tx_valid && tx_ready;
    if (sys_rst) begin
      left = 8'h00;
    end else if (got && left == 8'h00) begin
      left = tx_data - 8'h01;
    end else if (got) begin
      left = left - 8'h01;
    end
    got_data = tx_data;
    got_last = got && left == 8'h00;
  end
endmodule : cbf_host_model
`default_nettype wire

// ==== bench/tb_top.sv ====
// Testbench: blocks in, packets and verdicts out, outgoing blocks checked
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import cbf_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic rx_valid = 1'b0;
  logic [7:0] rx_data = 8'h00;
  logic pkt_ready = 1'b0;
  logic rsp_start = 1'b0;
  logic [7:0] rsp_len = 8'h00;
  logic rsp_valid = 1'b0;
  logic [7:0] rsp_data = 8'h00;
  logic err_req = 1'b0;
  logic [7:0] err_code = 8'h00;
  logic slow = 1'b0;
  logic rx_ready, pkt_valid, frame_ok, frame_err, rsp_ready;
  logic tx_valid, tx_ready, tx_busy, got, got_last;
  logic [7:0] pkt_data, frame_count, tx_data, got_data;
  logic [8:0] tx_q[$];
  logic [7:0] pkt_q[$];
  logic [9:0] fr_q[$];
  logic [8:0] exp_tx;
  logic [7:0] exp_pkt;
  logic [9:0] exp_fr;
  int n_fail = 0;
  int num_checks = 0;
  int seed = 43;
  int cyc = 0;
  int sz[$] = '{1, 81, 2, 50};
  logic [7:0] codes[$] = '{8'h00, 8'h01, 8'h03, 8'h0F, 8'h11, 8'hFF};

  cbf_framer #(.FIFO_W(8), .FIFO_D(8)) u_cbf_framer (
    .mclk(mclk), .sys_rst(sys_rst), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_data(rx_data), .pkt_valid(pkt_valid),
    .pkt_ready(pkt_ready), .pkt_data(pkt_data), .frame_ok(frame_ok),
    .frame_err(frame_err), .frame_count(frame_count),
    .rsp_start(rsp_start), .rsp_len(rsp_len), .rsp_valid(rsp_valid),
    .rsp_ready(rsp_ready), .rsp_data(rsp_data), .err_req(err_req),
    .err_code(err_code), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_data(tx_data), .tx_busy(tx_busy));

  cbf_host_model u_cbf_host_model (
    .mclk(mclk), .sys_rst(sys_rst), .slow(slow), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .got(got),
    .got_data(got_data), .got_last(got_last));

  //////////////////////////////////////////////////////////////////////////
  // Clock, executor stalls and the hang limit
  always #10 mclk = ~mclk;
  always @(posedge mclk) begin
    #1 pkt_ready = ($random(seed) & 3) != 0;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      summarize();
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Reporting and compares, one per kind of result
  task summarize;
    $display("checks=%0d failures=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  task chk_tx(input logic [8:0] g, input logic [8:0] e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH tx t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_tx
  task chk_pkt(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH pkt t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_pkt
  task chk_frame(input logic [9:0] g, input logic [9:0] e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH frame t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_frame

  // Monitors pop the oldest note whenever a result shows up
  always @(posedge mclk) begin
    if (got === 1'b1) begin
      exp_tx = tx_q.size() ? tx_q.pop_front() : 9'h1FF;
      chk_tx({got_last, got_data}, exp_tx);
    end
  end
  always @(negedge mclk) begin
    if (pkt_valid === 1'b1 && pkt_ready) begin
      exp_pkt = pkt_q.size() ? pkt_q.pop_front() : 8'hXX;
      chk_pkt(pkt_data, exp_pkt);
    end
    if (frame_ok === 1'b1 || frame_err === 1'b1) begin
      exp_fr = fr_q.size() ? fr_q.pop_front() : 10'h3FF;
      chk_frame({frame_ok, frame_err, frame_count}, exp_fr);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Reference checksum, bit 0 of each byte first
  function automatic logic [15:0] crc8(input logic [15:0] c,
                                       input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      if (d[i] ^ c[15]) c = {c[14:0], 1'b0} ^ CBF_CRC_POLY;
      else c = {c[14:0], 1'b0};
    end
    return c;
  endfunction : crc8

  task tick;
    @(posedge mclk);
    #1;
  endtask : tick

  // Notes a whole outgoing block: bytes, then checksum low, then high
  task push_tx(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'h0000;
    foreach (b[i]) c = crc8(c, b[i]);
    b.push_back(c[7:0]);
    b.push_back(c[15:8]);
    foreach (b[i]) tx_q.push_back({i == b.size() - 1, b[i]});
  endtask : push_tx

  // Holds a byte until ready was high at the taking edge
  task hs(input bit to_rsp, input logic [7:0] d);
    int n;
    n = 0;
    if (to_rsp) begin
      rsp_valid = 1'b1;
      rsp_data = d;
    end else begin
      rx_valid = 1'b1;
      rx_data = d;
    end
    while (!(to_rsp ? rsp_ready : rx_ready) && n < 2000) begin
      tick();
      n++;
    end
    // A byte that is never taken is a hang, counted as a mismatch
    if (n >= 2000) n_fail++;
    tick();
  endtask : hs

  // Waits, bounded, until every note has been matched and tx is idle
  task drain;
    int n;
    n = 0;
    rx_valid = 1'b0;
    rsp_valid = 1'b0;
    while ((tx_q.size() || pkt_q.size() || fr_q.size() || tx_busy !== 1'b0)
           && n < 3000) begin
      tick();
      n++;
    end
    // Notes left over or a stuck sender must not reach the pass verdict
    if (n >= 3000) n_fail++;
  endtask : drain

  //////////////////////////////////////////////////////////////////////////
  // Scenario tasks
  // Automatic, so each call starts from an empty byte list
  task automatic send_block(input int np, input bit bad);
    logic [7:0] b[$];
    logic [15:0] c;
    b.push_back(8'(np + 3));
    repeat (np) b.push_back(8'($random(seed)));
    c = 16'h0000;
    foreach (b[i]) c = crc8(c, b[i]);
    for (int i = 1; i <= np; i++) pkt_q.push_back(b[i]);
    fr_q.push_back({!bad, bad, b[0]});
    if (bad) push_tx('{8'h04, CBF_ST_COMM_ERR});
    c[0] = c[0] ^ bad;
    b.push_back(c[7:0]);
    b.push_back(c[15:8]);
    foreach (b[i]) hs(1'b0, b[i]);
  endtask : send_block

  task send_err(input logic [7:0] code);
    push_tx('{8'h04, code});
    err_req = 1'b1;
    err_code = code;
    tick();
    err_req = 1'b0;
    drain();
  endtask : send_err

  task automatic send_rsp(input int len);
    logic [7:0] b[$];
    b.push_back(8'(len + 3));
    repeat (len) b.push_back(8'($random(seed)));
    push_tx(b);
    rsp_start = 1'b1;
    rsp_len = 8'(len);
    tick();
    rsp_start = 1'b0;
    for (int i = 1; i <= len; i++) hs(1'b1, b[i]);
    drain();
  endtask : send_rsp

  //////////////////////////////////////////////////////////////////////////
  // Main sequence: back-to-back blocks, a bad checksum, status and replies
  initial begin
    repeat (16) @(posedge mclk);
    #1 sys_rst = 1'b0;
    tick();
    repeat (4) sz.push_back(($random(seed) & 63) + 1);
    foreach (sz[i]) begin
      slow = i[0];
      send_block(sz[i], 1'b0);
    end
    send_block(5, 1'b1);
    send_block(3, 1'b0);
    drain();
    foreach (codes[i]) send_err(codes[i]);
    slow = 1'b1;
    send_rsp(1);
    send_rsp(81);
    slow = 1'b0;
    send_rsp(7);
    summarize();
  end
endmodule : tb_top
`default_nettype wire
